// file: design/energy_cfg_pkg.sv
// Shared offsets, field positions and reset values of the metering configuration bank
package energy_cfg_pkg;
   // ************************************************
   // Register indices and byte addresses
   // ************************************************
   localparam logic [7:0] ACCUMULATION_MODE_IDX = 8'h0f;
   localparam logic [7:0] CHANNEL_GAIN_IDX = 8'h1b;
   localparam logic [7:0] CALIBRATION_CHANNEL_MODE_IDX = 8'h3d;
   localparam logic [7:0] SIGN_EVENT_STATUS_IDX = 8'h3e;
   localparam logic [9:0] ACCUMULATION_MODE_ADDR = {ACCUMULATION_MODE_IDX, 2'b00};
   localparam logic [9:0] CHANNEL_GAIN_ADDR = {CHANNEL_GAIN_IDX, 2'b00};
   localparam logic [9:0] CALIBRATION_CHANNEL_MODE_ADDR = {CALIBRATION_CHANNEL_MODE_IDX, 2'b00};
   localparam logic [9:0] SIGN_EVENT_STATUS_ADDR = {SIGN_EVENT_STATUS_IDX, 2'b00};
   // ************************************************
   // Field positions
   // ************************************************
   localparam int ACTIVE_CURRENT_INPUT_BIT = 7;
   localparam int FAULT_EVENT_SELECT_BIT = 6;
   localparam int REACTIVE_SIGN_EVENT_BIT = 5;
   localparam int ACTIVE_SIGN_EVENT_BIT = 4;
   localparam int REACTIVE_MAGNITUDE_MODE_BIT = 3;
   localparam int SIGN_ALIGNED_REACTIVE_MODE_BIT = 2;
   localparam int POSITIVE_ONLY_ACTIVE_MODE_BIT = 1;
   localparam int ACTIVE_MAGNITUDE_MODE_BIT = 0;
   localparam int VOLTAGE_GAIN_LSB = 5;
   localparam int SIGN_DETECT_SOURCE_BIT = 3;
   localparam int CURRENT_GAIN_LSB = 0;
   localparam int CURRENT_INPUT_SELECT_LSB = 4;
   localparam int VOLTAGE_INPUT_GROUND_BIT = 3;
   localparam int CURRENT_INPUTS_GROUND_BIT = 2;
   localparam int ACTIVE_SIGN_FLAG_BIT = 0;
   localparam int REACTIVE_SIGN_FLAG_BIT = 1;
   localparam int FAULT_EVENT_FLAG_BIT = 2;
   // ************************************************
   // Writable masks, reset values, codes
   // ************************************************
   localparam logic [7:0] ACCUMULATION_MODE_WMASK = 8'h7f;
   localparam logic [7:0] CHANNEL_GAIN_WMASK = 8'hef;
   localparam logic [7:0] CALIBRATION_CHANNEL_MODE_WMASK = 8'hfc;
   localparam logic [7:0] ACCUMULATION_MODE_RESET = 8'h00;
   localparam logic [7:0] CHANNEL_GAIN_RESET = 8'h00;
   localparam logic [7:0] CALIBRATION_CHANNEL_MODE_RESET = 8'h00;
   localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
   localparam logic [2:0] GAIN_CODE_UNITY = 3'h0;
   localparam logic [1:0] SELECT_FIRST_INPUT = 2'h1;
   localparam logic [1:0] SELECT_SECOND_INPUT = 2'h2;
endpackage : energy_cfg_pkg

// file: design/power_sign_monitor.sv
// Detects a chosen sign transition on a sampled power sign
module power_sign_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sign samples
   input wire logic sample,
   input wire logic negative,
   // 0 selects positive-to-negative, 1 negative-to-positive
   input wire logic to_positive_sel,
   // Event
   output logic event_pulse
);
   logic last_negative;
   logic have_last;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_negative <= 1'b0;
         have_last <= 1'b0;
      end else if (sample) begin
         last_negative <= negative;
         have_last <= 1'b1;
      end
   end

   // First sample only seeds the history: no sign to compare against yet
   always_comb begin
      event_pulse = sample && have_last && (last_negative != negative) &&
                    (to_positive_sel ? !negative : negative);
   end

   sign_direction_a: assert property (@(posedge pclk) disable iff (!presetn)
      event_pulse |-> (negative == !to_positive_sel) && (last_negative == to_positive_sel))
      else $error("sign event in wrong direction");
endmodule : power_sign_monitor

// file: design/power_accum_shaper.sv
// Conditions a power sample before energy accumulation
module power_accum_shaper #(
   parameter int WIDTH = 24
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sample in
   input wire logic in_valid,
   input wire logic signed [WIDTH-1:0] in_value,
   // Modes
   input wire logic magnitude_mode,
   input wire logic positive_only_mode,
   input wire logic negate,
   // Sample out
   output logic out_valid,
   output logic signed [WIDTH-1:0] out_value
);
   logic signed [WIDTH-1:0] next_value;

   // Magnitude wins over the other modes when software sets several
   always_comb begin
      next_value = in_value;
      if (magnitude_mode && in_value < 0) begin
         next_value = -in_value;
      end else if (!magnitude_mode && positive_only_mode && in_value < 0) begin
         next_value = '0;
      end else if (!magnitude_mode && negate) begin
         next_value = -in_value;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_value <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_value <= next_value;
         end
      end
   end

   pos_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      in_valid && positive_only_mode && !magnitude_mode && in_value < 0 |=> out_value == 0)
      else $error("negative power passed in positive-only mode");
   magnitude_a: assert property (@(posedge pclk) disable iff (!presetn)
      in_valid && magnitude_mode |=> out_value == (($past(in_value) < 0) ? -$past(in_value) : $past(in_value)))
      else $error("magnitude mode output wrong");
endmodule : power_accum_shaper

// file: design/energy_accum_mode_config.sv
// Accumulation mode, gain and channel configuration bank with its control logic
//
// How it works
// - Status bit 7 shows which current input the measurement uses: 0 first, 1 second.
// - Fault event select 0 flags entering fault; 1 flags return to normal.
// - Reactive sign event 0 flags positive-to-negative; 1 flags negative-to-positive.
// - Active sign event 0 flags positive-to-negative; 1 flags negative-to-positive.
// - Reactive magnitude mode accumulates absolute reactive power.
// - Sign-aligned mode negates reactive power while active power is negative.
// - Positive-only mode drops negative active power from accumulation.
// - Active magnitude mode accumulates absolute active power.
// - Voltage gain code in bits 7:5 picks gains 1,2,4,8,16.
// - Current gain code in bits 2:0 picks gains 1,2,4,8,16.
// - Sign detect source: 0 filtered power, 1 per energy pulse.
// - Input select 01 forces first, 10 second, otherwise tamper logic picks.
// - Voltage ground bit zeroes the voltage channel.
// - Current ground bit zeroes both current inputs.
// - Accumulation mode bits reset to zero.
// - Active sign flag sets on the selected active sign transition.
//
// Implementation choice: the APB register port.
module energy_accum_mode_config #(
   parameter int POWER_W = 24,
   parameter int SAMPLE_W = 24
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Filtered power samples
   input wire logic power_valid,
   input wire logic signed [POWER_W-1:0] active_power,
   input wire logic signed [POWER_W-1:0] reactive_power,
   // Energy pulses with their sign
   input wire logic active_pulse,
   input wire logic active_pulse_negative,
   input wire logic reactive_pulse,
   input wire logic reactive_pulse_negative,
   // Tamper logic
   input wire logic tamper_fault,
   input wire logic tamper_pick_second,
   // Channel samples in
   input wire logic signed [SAMPLE_W-1:0] first_current_input,
   input wire logic signed [SAMPLE_W-1:0] second_current_input,
   input wire logic signed [SAMPLE_W-1:0] voltage_input,
   // Channel samples out
   output logic signed [SAMPLE_W-1:0] current_sample,
   output logic signed [SAMPLE_W-1:0] voltage_sample,
   // Channel control
   output logic [2:0] voltage_gain_code,
   output logic [2:0] current_gain_code,
   output logic active_current_input,
   output logic voltage_input_ground,
   output logic current_inputs_ground,
   // Conditioned power for accumulation
   output logic active_accum_valid,
   output logic signed [POWER_W-1:0] active_accum,
   output logic reactive_accum_valid,
   output logic signed [POWER_W-1:0] reactive_accum,
   // Sticky event flags
   output logic active_sign_flag,
   output logic reactive_sign_flag,
   output logic fault_event_flag
);
   // ************************************************
   // Register state
   // ************************************************
   logic [6:0] accumulation_mode;
   logic [7:0] channel_gain;
   logic [7:0] calibration_channel_mode;
   logic fault_last;
   logic active_event;
   logic reactive_event;
   logic fault_event;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [2:0] status_clear;

   function automatic logic at(input logic [9:0] addr, input logic [9:0] reg_addr);
      at = (addr == reg_addr);
   endfunction : at

   function automatic logic [2:0] clamp_gain(input logic [2:0] code);
      clamp_gain = (code > energy_cfg_pkg::GAIN_CODE_MAX) ? energy_cfg_pkg::GAIN_CODE_UNITY : code;
   endfunction : clamp_gain

   // ************************************************
   // APB slave
   // ************************************************
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign hit = at(paddr, energy_cfg_pkg::ACCUMULATION_MODE_ADDR) ||
                at(paddr, energy_cfg_pkg::CHANNEL_GAIN_ADDR) ||
                at(paddr, energy_cfg_pkg::CALIBRATION_CHANNEL_MODE_ADDR) ||
                at(paddr, energy_cfg_pkg::SIGN_EVENT_STATUS_ADDR);
   assign pslverr = psel && penable && !hit;
   assign wr_en = psel && penable && pwrite && hit;
   assign rd_en = psel && penable && !pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accumulation_mode <= energy_cfg_pkg::ACCUMULATION_MODE_RESET[6:0];
      end else if (wr_en && at(paddr, energy_cfg_pkg::ACCUMULATION_MODE_ADDR)) begin
         accumulation_mode <= pwdata[6:0] & energy_cfg_pkg::ACCUMULATION_MODE_WMASK[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_gain <= energy_cfg_pkg::CHANNEL_GAIN_RESET;
      end else if (wr_en && at(paddr, energy_cfg_pkg::CHANNEL_GAIN_ADDR)) begin
         channel_gain <= pwdata[7:0] & energy_cfg_pkg::CHANNEL_GAIN_WMASK;
      end
   end

   // Bits 7:6 are stored as written; software is expected to leave them zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         calibration_channel_mode <= energy_cfg_pkg::CALIBRATION_CHANNEL_MODE_RESET;
      end else if (wr_en && at(paddr, energy_cfg_pkg::CALIBRATION_CHANNEL_MODE_ADDR)) begin
         calibration_channel_mode <= pwdata[7:0] & energy_cfg_pkg::CALIBRATION_CHANNEL_MODE_WMASK;
      end
   end

   assign status_clear = (wr_en && at(paddr, energy_cfg_pkg::SIGN_EVENT_STATUS_ADDR)) ? pwdata[2:0] : 3'h0;

   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         if (at(paddr, energy_cfg_pkg::ACCUMULATION_MODE_ADDR)) begin
            prdata[7:0] = {active_current_input, accumulation_mode};
         end else if (at(paddr, energy_cfg_pkg::CHANNEL_GAIN_ADDR)) begin
            prdata[7:0] = channel_gain;
         end else if (at(paddr, energy_cfg_pkg::CALIBRATION_CHANNEL_MODE_ADDR)) begin
            prdata[7:0] = calibration_channel_mode;
         end else if (at(paddr, energy_cfg_pkg::SIGN_EVENT_STATUS_ADDR)) begin
            prdata[2:0] = {fault_event_flag, reactive_sign_flag, active_sign_flag};
         end
      end
   end

   // ************************************************
   // Channel control
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage_gain_code <= energy_cfg_pkg::GAIN_CODE_UNITY;
         current_gain_code <= energy_cfg_pkg::GAIN_CODE_UNITY;
      end else begin
         voltage_gain_code <= clamp_gain(channel_gain[energy_cfg_pkg::VOLTAGE_GAIN_LSB +: 3]);
         current_gain_code <= clamp_gain(channel_gain[energy_cfg_pkg::CURRENT_GAIN_LSB +: 3]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_current_input <= 1'b0;
      end else begin
         case (calibration_channel_mode[energy_cfg_pkg::CURRENT_INPUT_SELECT_LSB +: 2])
            energy_cfg_pkg::SELECT_FIRST_INPUT: active_current_input <= 1'b0;
            energy_cfg_pkg::SELECT_SECOND_INPUT: active_current_input <= 1'b1;
            default: active_current_input <= tamper_pick_second;
         endcase
      end
   end

   assign voltage_input_ground = calibration_channel_mode[energy_cfg_pkg::VOLTAGE_INPUT_GROUND_BIT];
   assign current_inputs_ground = calibration_channel_mode[energy_cfg_pkg::CURRENT_INPUTS_GROUND_BIT];

   // Grounding acts on the samples so the datapath sees a true zero signal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage_sample <= '0;
         current_sample <= '0;
      end else begin
         voltage_sample <= voltage_input_ground ? '0 : voltage_input;
         if (current_inputs_ground) begin
            current_sample <= '0;
         end else begin
            current_sample <= active_current_input ? second_current_input : first_current_input;
         end
      end
   end

   // ************************************************
   // Accumulation shaping
   // ************************************************
   power_accum_shaper #(.WIDTH(POWER_W)) active_shaper (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(power_valid),
      .in_value(active_power),
      .magnitude_mode(accumulation_mode[energy_cfg_pkg::ACTIVE_MAGNITUDE_MODE_BIT]),
      .positive_only_mode(accumulation_mode[energy_cfg_pkg::POSITIVE_ONLY_ACTIVE_MODE_BIT]),
      .negate(1'b0),
      .out_valid(active_accum_valid),
      .out_value(active_accum)
   );

   power_accum_shaper #(.WIDTH(POWER_W)) reactive_shaper (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(power_valid),
      .in_value(reactive_power),
      .magnitude_mode(accumulation_mode[energy_cfg_pkg::REACTIVE_MAGNITUDE_MODE_BIT]),
      .positive_only_mode(1'b0),
      .negate(accumulation_mode[energy_cfg_pkg::SIGN_ALIGNED_REACTIVE_MODE_BIT] && active_power < 0),
      .out_valid(reactive_accum_valid),
      .out_value(reactive_accum)
   );

   // ************************************************
   // Sign and fault events
   // ************************************************
   logic sign_from_pulse;
   assign sign_from_pulse = channel_gain[energy_cfg_pkg::SIGN_DETECT_SOURCE_BIT];

   power_sign_monitor active_monitor (
      .pclk(pclk),
      .presetn(presetn),
      .sample(sign_from_pulse ? active_pulse : power_valid),
      .negative(sign_from_pulse ? active_pulse_negative : active_power < 0),
      .to_positive_sel(accumulation_mode[energy_cfg_pkg::ACTIVE_SIGN_EVENT_BIT]),
      .event_pulse(active_event)
   );

   power_sign_monitor reactive_monitor (
      .pclk(pclk),
      .presetn(presetn),
      .sample(sign_from_pulse ? reactive_pulse : power_valid),
      .negative(sign_from_pulse ? reactive_pulse_negative : reactive_power < 0),
      .to_positive_sel(accumulation_mode[energy_cfg_pkg::REACTIVE_SIGN_EVENT_BIT]),
      .event_pulse(reactive_event)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_last <= 1'b0;
      end else begin
         fault_last <= tamper_fault;
      end
   end

   assign fault_event = accumulation_mode[energy_cfg_pkg::FAULT_EVENT_SELECT_BIT] ?
                        (fault_last && !tamper_fault) : (!fault_last && tamper_fault);

   // Write-one-to-clear; an event in the clearing cycle keeps its flag set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_sign_flag <= 1'b0;
         reactive_sign_flag <= 1'b0;
         fault_event_flag <= 1'b0;
      end else begin
         active_sign_flag <= active_event ||
                             (active_sign_flag && !status_clear[energy_cfg_pkg::ACTIVE_SIGN_FLAG_BIT]);
         reactive_sign_flag <= reactive_event ||
                               (reactive_sign_flag && !status_clear[energy_cfg_pkg::REACTIVE_SIGN_FLAG_BIT]);
         fault_event_flag <= fault_event ||
                             (fault_event_flag && !status_clear[energy_cfg_pkg::FAULT_EVENT_FLAG_BIT]);
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   mode_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> accumulation_mode == 7'h00)
      else $error("accumulation mode not zero after reset");
   active_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      active_event |=> active_sign_flag)
      else $error("active sign event lost");
   fault_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
      !accumulation_mode[6] && $rose(tamper_fault) |=> fault_event_flag)
      else $error("fault entry not flagged");
   fault_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
      accumulation_mode[6] && fault_event |-> $past(tamper_fault) && !tamper_fault)
      else $error("fault flag on wrong edge");
   select_first_a: assert property (@(posedge pclk) disable iff (!presetn)
      calibration_channel_mode[5:4] == 2'h1 |=> !active_current_input)
      else $error("first input not forced");
   select_tamper_a: assert property (@(posedge pclk) disable iff (!presetn)
      calibration_channel_mode[5] == calibration_channel_mode[4] |=> active_current_input == $past(tamper_pick_second))
      else $error("tamper choice not followed");
   voltage_ground_a: assert property (@(posedge pclk) disable iff (!presetn)
      voltage_input_ground |=> voltage_sample == 0)
      else $error("grounded voltage channel not zero");
   current_ground_a: assert property (@(posedge pclk) disable iff (!presetn)
      current_inputs_ground |=> current_sample == 0)
      else $error("grounded current channel not zero");
   gain_unity_a: assert property (@(posedge pclk) disable iff (!presetn)
      channel_gain[2:0] > 3'h4 |=> current_gain_code == 3'h0)
      else $error("reserved gain code not unity");
   gain_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      channel_gain[7:5] <= 3'h4 |=> voltage_gain_code == $past(channel_gain[7:5]))
      else $error("voltage gain code not applied");
   gain_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && at(paddr, energy_cfg_pkg::CHANNEL_GAIN_ADDR) |-> prdata[31:8] == 0 && !prdata[4])
      else $error("reserved gain bits read nonzero");
   reactive_mag_a: assert property (@(posedge pclk) disable iff (!presetn)
      power_valid && accumulation_mode[3] |=> reactive_accum >= 0 || $past(reactive_power) == {1'b1, {(POWER_W-1){1'b0}}})
      else $error("reactive magnitude negative");
   aligned_a: assert property (@(posedge pclk) disable iff (!presetn)
      power_valid && accumulation_mode[3:2] == 2'b01 && active_power < 0 |=> reactive_accum == -$past(reactive_power))
      else $error("reactive not negated");
   gain_current_a: assert property (@(posedge pclk) disable iff (!presetn)
      channel_gain[2:0] <= 3'h4 |=> current_gain_code == $past(channel_gain[2:0]))
      else $error("current gain code not applied");
   reactive_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
      reactive_event && !sign_from_pulse |-> (reactive_power < 0) != accumulation_mode[5])
      else $error("reactive sign event in wrong direction");
   pulse_source_a: assert property (@(posedge pclk) disable iff (!presetn)
      sign_from_pulse && !active_pulse && !reactive_pulse |-> !active_event && !reactive_event)
      else $error("sign event without energy pulse");
   status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && at(paddr, energy_cfg_pkg::ACCUMULATION_MODE_ADDR) |-> prdata[7] == active_current_input)
      else $error("current input status misread");
   flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      status_clear[0] && !active_event |=> !active_sign_flag)
      else $error("active sign flag not cleared");
   fault_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      fault_event |=> fault_event_flag)
      else $error("fault event lost");

   // ************************************************
   // Cover points
   // ************************************************
   fault_cov_c: cover property (@(posedge pclk) disable iff (!presetn) fault_event);
   reactive_cov_c: cover property (@(posedge pclk) disable iff (!presetn) reactive_event && sign_from_pulse);
   clear_race_c: cover property (@(posedge pclk) disable iff (!presetn) active_event && status_clear[0]);
   pulse_sign_c: cover property (@(posedge pclk) disable iff (!presetn) active_event && sign_from_pulse);
   fault_exit_c: cover property (@(posedge pclk) disable iff (!presetn) fault_event && accumulation_mode[6]);
endmodule : energy_accum_mode_config

// file: tb/tb_energy_accum_mode_config.sv
// Self-checking bench for the accumulation mode and channel configuration bank
module tb_energy_accum_mode_config;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Signals
   // ****************************************
   localparam logic [9:0] ACC = energy_cfg_pkg::ACCUMULATION_MODE_ADDR;
   localparam logic [9:0] GAIN = energy_cfg_pkg::CHANNEL_GAIN_ADDR;
   localparam logic [9:0] CAL = energy_cfg_pkg::CALIBRATION_CHANNEL_MODE_ADDR;
   localparam logic [9:0] STAT = energy_cfg_pkg::SIGN_EVENT_STATUS_ADDR;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, power_valid, tamper_fault, tamper_pick_second;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [23:0] active_power, reactive_power, active_accum, reactive_accum, current_sample, voltage_sample;
   logic [2:0] voltage_gain_code, current_gain_code;
   logic active_current_input, voltage_input_ground, current_inputs_ground, active_accum_valid, reactive_accum_valid;
   logic active_sign_flag, reactive_sign_flag, fault_event_flag, pulse, pulse_neg;
   int err_total = 0;
   int num_checks = 0;
   energy_accum_mode_config energy_accum_mode_config_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_valid(power_valid), .active_power(active_power), .reactive_power(reactive_power),
      .active_pulse(pulse), .active_pulse_negative(pulse_neg), .reactive_pulse(pulse),
      .reactive_pulse_negative(pulse_neg),
      .tamper_fault(tamper_fault), .tamper_pick_second(tamper_pick_second), .first_current_input(active_power),
      .second_current_input(reactive_power), .voltage_input(active_power), .current_sample(current_sample),
      .voltage_sample(voltage_sample), .voltage_gain_code(voltage_gain_code), .current_gain_code(current_gain_code),
      .active_current_input(active_current_input), .voltage_input_ground(voltage_input_ground),
      .current_inputs_ground(current_inputs_ground), .active_accum_valid(active_accum_valid),
      .active_accum(active_accum), .reactive_accum_valid(reactive_accum_valid), .reactive_accum(reactive_accum),
      .active_sign_flag(active_sign_flag), .reactive_sign_flag(reactive_sign_flag),
      .fault_event_flag(fault_event_flag));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_of_test;
      if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle
   task automatic pw(input logic signed [23:0] a, input logic signed [23:0] r);
      @(posedge pclk);
      power_valid <= 1'b1;
      active_power <= a;
      reactive_power <= r;
      @(posedge pclk);
      power_valid <= 1'b0;
      #1 chk({active_accum_valid, reactive_accum_valid}, 32'h3);
      settle();
   endtask : pw
   task automatic pp(input logic n);
      @(posedge pclk);
      pulse <= 1'b1;
      pulse_neg <= n;
      @(posedge pclk);
      pulse <= 1'b0;
      settle();
   endtask : pp
   // ****************************************
   // Clock, watchdog and tests
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      repeat (3000) @(posedge pclk);
      err_total++;
      end_of_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, power_valid, tamper_fault, tamper_pick_second, pulse, pulse_neg} = '0;
      {paddr, pwdata, active_power, reactive_power} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ACC, 8'h00); chk(rd, 32'h0);
      apb(0, 10'h3f0, 8'h00); chk({31'h0, er}, 32'h1);
      apb(1, GAIN, 8'hff); apb(0, GAIN, 8'h00); chk(rd, 32'hef);
      settle(); chk({voltage_gain_code, current_gain_code}, 32'h0);
      for (int k = 0; k < 5; k++) begin
         apb(1, GAIN, {k[2:0], 2'b00, 3'(k % 4 + 1)});
         settle(); chk({voltage_gain_code, current_gain_code}, {k[2:0], 3'(k % 4 + 1)});
      end
      pw(24'sd5, -24'sd7);
      apb(1, ACC, 8'h09); pw(-24'sd5, -24'sd7);
      chk(active_accum, 24'sd5);
      chk(reactive_accum, 24'sd7);
      chk({active_sign_flag, reactive_sign_flag}, 32'h2);
      apb(1, ACC, 8'h06); pw(-24'sd5, 24'sd7);
      chk(active_accum, 32'h0);
      chk(reactive_accum, -24'sd7);
      chk(reactive_sign_flag, 32'h0);
      apb(1, ACC, 8'h30); apb(1, STAT, 8'h07);
      pw(24'sd5, -24'sd7); chk({active_sign_flag, reactive_sign_flag}, 32'h2);
      pw(24'sd5, 24'sd7); chk(reactive_sign_flag, 32'h1);
      apb(1, CAL, 8'h10); settle(); chk({active_current_input, current_sample}, {1'b0, active_power});
      apb(1, CAL, 8'h20); settle(); chk({active_current_input, current_sample}, {1'b1, reactive_power});
      apb(0, ACC, 8'h00); chk(rd, 32'hb0);
      apb(1, CAL, 8'h30); settle(); chk(active_current_input, 32'h0);
      @(posedge pclk); tamper_pick_second <= 1'b1; settle(); chk(active_current_input, 32'h1);
      apb(1, CAL, 8'h0c); settle(); chk(current_sample, 32'h0); chk(voltage_sample, 32'h0);
      chk({voltage_input_ground, current_inputs_ground}, 32'h3);
      apb(1, STAT, 8'h07); tamper_fault <= 1'b1; settle(); chk(fault_event_flag, 32'h1);
      apb(1, ACC, 8'h40); apb(1, STAT, 8'h04); settle(); chk(fault_event_flag, 32'h0);
      @(posedge pclk); tamper_fault <= 1'b0; settle(); chk(fault_event_flag, 32'h1);
      apb(1, GAIN, 8'h89); apb(1, STAT, 8'h07); pw(-24'sd5, -24'sd7);
      chk({active_sign_flag, reactive_sign_flag}, 32'h0);
      pp(1'b1); chk({active_sign_flag, reactive_sign_flag}, 32'h3);
      @(posedge pclk); presetn <= 1'b0; repeat (2) @(posedge pclk); presetn <= 1'b1;
      apb(0, ACC, 8'h00); chk(rd, 32'h80);
      apb(0, GAIN, 8'h00); chk(rd, 32'h0);
      end_of_test();
   end
endmodule : tb_energy_accum_mode_config
